// >>> hdl/phs_pkg.sv
/*
 Package for the PCI handshake block: command codes, cycle counts,
 carrier structs and command decode helpers.
 Assumes one PCI clock and one synchronous bus reset for the whole block.
*/
// How it works
// - Target ready only with data ready
// - Data phase ends when both readies low
// - Target may stop; master honours stop
// - One lock owner; others get retried
// - Master never drives lock
// - Config access claimed only with select
// - Device select after own address decode
// - Interrupt A held while pending
// - Own request line to arbiter
// - Master starts only after grant
// - Parity error two clocks after phase
// - Parity error driven high one clock
// - System error on severe parity faults
// - Even parity one clock after phase
package phs_pkg;
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_MEM_RDM = 4'hc;
	localparam logic [3:0] CMD_MEM_RDL = 4'he;
	localparam logic [3:0] CMD_MEM_WRI = 4'hf;
	localparam logic [2:0] CFG_HI_BITS = 3'h5;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	localparam logic [2:0] ABORT_CYC = 3'h5;
	localparam logic [31:0] ADDR_STEP = 32'h4;
	localparam logic [31:0] RST_WORD = 32'h0;

	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [3:0] be;
		logic [31:0] data;
	} phs_xfer_t;

	typedef struct packed {
		logic retry;
		logic abort;
		logic [31:0] rdata;
	} phs_mres_t;

	function automatic logic cmd_is_read(input logic [3:0] c);
		return !c[0];
	endfunction

	function automatic logic cmd_is_mem(input logic [3:0] c);
		return (c == CMD_MEM_RD) || (c == CMD_MEM_WR) || (c == CMD_MEM_RDM) ||
			(c == CMD_MEM_RDL) || (c == CMD_MEM_WRI);
	endfunction

	function automatic logic cmd_is_cfg(input logic [3:0] c);
		return c[3:1] == CFG_HI_BITS;
	endfunction
endpackage

// >>> hdl/phs_parity_unit.sv
/*
 Parity generation and checking for the PCI handshake block.
 Assumes ad_i and cbe_n_i show the resolved bus wires, including our own drive.
*/
`timescale 1ns/1ps
`default_nettype none
module phs_parity_unit (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [31:0] ad_i,
	input wire logic [3:0] cbe_n_i,
	input wire logic par_i,
	input wire logic drv,
	input wire logic rx_data,
	input wire logic rx_sys,
	input wire logic fatal,
	output logic par_o,
	output logic par_oe,
	output logic perr_n_o,
	output logic perr_n_oe,
	output logic serr_n_oe
);
	logic par_r, par_oe_r, sum_r, chk_r, sys_r, perr_lo_r, perr_hi_r, serr_r;
	wire logic sum_w = ^{ad_i, cbe_n_i};
	wire logic bad_w = chk_r && (par_i != sum_r);
	wire logic perr_nxt = bad_w && !sys_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			par_r <= 1'b0;
			par_oe_r <= 1'b0;
			sum_r <= 1'b0;
			chk_r <= 1'b0;
			sys_r <= 1'b0;
			perr_lo_r <= 1'b0;
			perr_hi_r <= 1'b0;
			serr_r <= 1'b0;
		end else begin
			par_r <= sum_w;
			par_oe_r <= drv;
			sum_r <= sum_w;
			chk_r <= rx_data || rx_sys;
			sys_r <= rx_sys;
			perr_lo_r <= perr_nxt;
			perr_hi_r <= perr_lo_r && !perr_nxt;
			serr_r <= (bad_w && sys_r) || fatal;
		end
	end

	assign par_o = par_r;
	assign par_oe = par_oe_r;
	assign perr_n_o = !perr_lo_r;
	assign perr_n_oe = perr_lo_r || perr_hi_r;
	assign serr_n_oe = serr_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_dbad;
		rx_data && !rx_sys ##1 (par_i != ^{$past(ad_i), $past(cbe_n_i)});
	endsequence
	sequence s_sbad;
		rx_sys ##1 (par_i != ^{$past(ad_i), $past(cbe_n_i)});
	endsequence

	property p_perr_two;
		s_dbad |=> (perr_n_oe && !perr_n_o);
	endproperty
	a_perr_two: assert property (p_perr_two) else $error("parity error not reported");
	property p_perr_rel;
		$fell(perr_n_oe) |-> $past(perr_n_o);
	endproperty
	a_perr_rel: assert property (p_perr_rel) else $error("perr released while low");
	property p_perr_hi;
		(perr_n_oe && !perr_n_o) ##1 perr_n_o |-> perr_n_oe;
	endproperty
	a_perr_hi: assert property (p_perr_hi) else $error("perr not driven high");
	property p_par_even;
		par_oe |-> (par_o == ^{$past(ad_i), $past(cbe_n_i)}) && $past(drv);
	endproperty
	a_par_even: assert property (p_par_even) else $error("parity not even");
	property p_serr;
		s_sbad |=> serr_n_oe;
	endproperty
	a_serr: assert property (p_serr) else $error("system error missing");
endmodule
`default_nettype wire

// >>> hdl/phs_pci_handshake.sv
/*
 PCI target and master handshake: claims cycles, forms wait states, retries
 locked access, requests the bus, runs single-word master cycles.
 Assumes bus wires are resolved outside and all pins are on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module phs_pci_handshake #(
	parameter logic [31:0] BAR_BASE = 32'h8000_0000,
	parameter logic [31:0] BAR_MASK = 32'hffff_f000
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [31:0] ad_i,
	output logic [31:0] ad_o,
	output logic ad_oe,
	input wire logic [3:0] cbe_n_i,
	output logic [3:0] cbe_n_o,
	output logic cbe_n_oe,
	input wire logic par_i,
	output logic par_o,
	output logic par_oe,
	input wire logic frame_n_i,
	output logic frame_n_o,
	output logic frame_n_oe,
	input wire logic irdy_n_i,
	output logic irdy_n_o,
	output logic irdy_n_oe,
	input wire logic trdy_n_i,
	output logic trdy_n_o,
	output logic trdy_n_oe,
	input wire logic stop_n_i,
	output logic stop_n_o,
	output logic stop_n_oe,
	input wire logic devsel_n_i,
	output logic devsel_n_o,
	output logic devsel_n_oe,
	input wire logic lock_n_i,
	input wire logic idsel_i,
	output logic perr_n_o,
	output logic perr_n_oe,
	output logic serr_n_o,
	output logic serr_n_oe,
	output logic inta_n_o,
	output logic inta_n_oe,
	output logic req_n,
	input wire logic gnt_n,
	input wire logic [31:0] tgt_rdata,
	input wire logic tgt_ready,
	input wire logic tgt_stop,
	output logic tgt_xfer,
	output phs_pkg::phs_xfer_t tgt_info,
	input wire logic irq_pending,
	input wire logic fatal_err,
	input wire logic mst_start,
	input wire phs_pkg::phs_xfer_t mst_req,
	output logic mst_busy,
	output logic mst_done,
	output phs_pkg::phs_mres_t mst_res
);
	typedef enum logic [3:0] {
		T_IDLE = 4'b0001,
		T_DATA = 4'b0010,
		T_SPC = 4'b0100,
		T_TURN = 4'b1000
	} phs_tst_t;
	typedef enum logic [4:0] {
		M_IDLE = 5'b00001,
		M_REQ = 5'b00010,
		M_ADDR = 5'b00100,
		M_DATA = 5'b01000,
		M_TURN = 5'b10000
	} phs_mst_t;

	phs_tst_t t_st_r, t_nxt;
	phs_mst_t m_st_r, m_nxt;
	logic frame_q_r, trdy_r, stop_r, retry_r, lk_first_r, locked_r, tad_oe_r, int_r;
	logic [31:0] addr_r, tad_r;
	logic [3:0] cmd_r;
	logic [2:0] m_cnt_r;
	logic tgt_xfer_r, mdone_r;
	phs_pkg::phs_xfer_t tinfo_r, mreq_r;
	phs_pkg::phs_mres_t mres_r;

	// Own address phases are not decoded, so the block never claims itself
	wire logic addr_ph = !frame_n_i && frame_q_r && (m_st_r != M_ADDR);
	wire logic cfg_hit = phs_pkg::cmd_is_cfg(cbe_n_i) && idsel_i &&
		(ad_i[1:0] == phs_pkg::CFG_TYPE0);
	wire logic mem_hit = phs_pkg::cmd_is_mem(cbe_n_i) && ((ad_i & BAR_MASK) == BAR_BASE);
	wire logic tgt_hit = addr_ph && (cfg_hit || mem_hit);
	wire logic spc_ph = addr_ph && (cbe_n_i == phs_pkg::CMD_SPECIAL);
	wire logic in_data = t_st_r == T_DATA;
	wire logic rd = phs_pkg::cmd_is_read(cmd_r);
	wire logic dphase_done = trdy_r && !irdy_n_i;
	wire logic end_now = frame_n_i && (irdy_n_i || dphase_done || stop_r);
	wire logic trdy_hold = trdy_r && irdy_n_i;
	// Reads wait for the turnaround so target ready never precedes data
	wire logic trdy_new = !retry_r && tgt_ready && (!rd || tad_oe_r) &&
		!(stop_r && dphase_done);
	wire logic trdy_nxt = in_data && !end_now && (trdy_hold || trdy_new);
	wire logic stop_nxt = in_data && !end_now && (retry_r || tgt_stop || stop_r);
	wire logic lock_set = dphase_done && lk_first_r && !lock_n_i;
	wire logic lock_clr = frame_n_i && lock_n_i && (t_st_r == T_IDLE);
	wire logic m_rd = phs_pkg::cmd_is_read(mreq_r.cmd);
	wire logic m_end = !trdy_n_i || !stop_n_i ||
		((m_cnt_r == phs_pkg::ABORT_CYC) && devsel_n_i);
	wire logic m_rx = (m_st_r == M_DATA) && !trdy_n_i && m_rd;
	wire logic t_rx = in_data && dphase_done && !rd;
	wire logic s_rx = (t_st_r == T_SPC) && !irdy_n_i;
	wire logic m_ad_oe = (m_st_r == M_ADDR) || ((m_st_r == M_DATA) && !m_rd);

	always_comb begin
		t_nxt = t_st_r;
		unique case (t_st_r)
			T_IDLE: begin
				if (tgt_hit) begin
					t_nxt = T_DATA;
				end else if (spc_ph) begin
					t_nxt = T_SPC;
				end
			end
			T_DATA: begin
				if (end_now) begin
					t_nxt = T_TURN;
				end
			end
			T_SPC: begin
				if (frame_n_i && irdy_n_i) begin
					t_nxt = T_IDLE;
				end
			end
			T_TURN: t_nxt = T_IDLE;
			default: t_nxt = T_IDLE;
		endcase
	end

	always_comb begin
		m_nxt = m_st_r;
		unique case (m_st_r)
			M_IDLE: begin
				if (mst_start) begin
					m_nxt = M_REQ;
				end
			end
			M_REQ: begin
				if (!gnt_n && frame_n_i && irdy_n_i) begin
					m_nxt = M_ADDR;
				end
			end
			M_ADDR: m_nxt = M_DATA;
			M_DATA: begin
				if (m_end) begin
					m_nxt = M_TURN;
				end
			end
			M_TURN: m_nxt = M_IDLE;
			default: m_nxt = M_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			t_st_r <= T_IDLE;
			m_st_r <= M_IDLE;
			frame_q_r <= 1'b1;
			trdy_r <= 1'b0;
			stop_r <= 1'b0;
			tad_oe_r <= 1'b0;
			int_r <= 1'b0;
		end else begin
			t_st_r <= t_nxt;
			m_st_r <= m_nxt;
			frame_q_r <= frame_n_i;
			trdy_r <= trdy_nxt;
			stop_r <= stop_nxt;
			tad_oe_r <= in_data && rd && !end_now;
			int_r <= irq_pending;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_r <= phs_pkg::RST_WORD;
			cmd_r <= phs_pkg::CMD_SPECIAL;
			retry_r <= 1'b0;
			lk_first_r <= 1'b0;
			locked_r <= 1'b0;
		end else begin
			if (tgt_hit && (t_st_r == T_IDLE)) begin
				addr_r <= ad_i;
				cmd_r <= cbe_n_i;
				retry_r <= locked_r && !lock_n_i;
				lk_first_r <= lock_n_i;
			end else if (dphase_done) begin
				addr_r <= addr_r + phs_pkg::ADDR_STEP;
			end
			// A new lock taken in the same cycle as a release still holds
			locked_r <= lock_set || (locked_r && !lock_clr);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tad_r <= phs_pkg::RST_WORD;
			tgt_xfer_r <= 1'b0;
			tinfo_r <= '0;
		end else begin
			if (trdy_nxt && !trdy_hold) begin
				tad_r <= tgt_rdata;
			end
			tgt_xfer_r <= in_data && dphase_done;
			if (in_data && dphase_done) begin
				tinfo_r <= {addr_r, cmd_r, ~cbe_n_i, rd ? tad_r : ad_i};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mreq_r <= '0;
			m_cnt_r <= 3'h0;
			mdone_r <= 1'b0;
			mres_r <= '0;
		end else begin
			if ((m_st_r == M_IDLE) && mst_start) begin
				mreq_r <= mst_req;
			end
			if (m_st_r == M_DATA) begin
				m_cnt_r <= m_cnt_r + 3'h1;
			end else begin
				m_cnt_r <= 3'h0;
			end
			mdone_r <= (m_st_r == M_DATA) && m_end;
			if ((m_st_r == M_DATA) && m_end) begin
				mres_r.retry <= trdy_n_i && !stop_n_i;
				mres_r.abort <= trdy_n_i && stop_n_i;
				mres_r.rdata <= ad_i;
			end
		end
	end

	// Lock is only ever sampled; the block has no way to drive it
	assign req_n = m_st_r != M_REQ;
	assign frame_n_o = m_st_r != M_ADDR;
	assign frame_n_oe = (m_st_r == M_ADDR) || (m_st_r == M_DATA);
	assign irdy_n_o = m_st_r != M_DATA;
	assign irdy_n_oe = (m_st_r == M_DATA) || (m_st_r == M_TURN);
	assign cbe_n_o = (m_st_r == M_ADDR) ? mreq_r.cmd : ~mreq_r.be;
	assign cbe_n_oe = frame_n_oe;
	assign ad_o = (m_st_r == M_ADDR) ? mreq_r.addr : (m_ad_oe ? mreq_r.data : tad_r);
	assign ad_oe = m_ad_oe || tad_oe_r;
	assign devsel_n_o = !in_data;
	assign trdy_n_o = !trdy_r;
	assign stop_n_o = !stop_r;
	assign devsel_n_oe = in_data || (t_st_r == T_TURN);
	assign trdy_n_oe = devsel_n_oe;
	assign stop_n_oe = devsel_n_oe;
	assign inta_n_o = 1'b0;
	assign inta_n_oe = int_r;
	assign serr_n_o = 1'b0;
	assign tgt_xfer = tgt_xfer_r;
	assign tgt_info = tinfo_r;
	assign mst_busy = m_st_r != M_IDLE;
	assign mst_done = mdone_r;
	assign mst_res = mres_r;

	phs_parity_unit u_par (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.ad_i(ad_i),
		.cbe_n_i(cbe_n_i),
		.par_i(par_i),
		.drv(ad_oe),
		.rx_data(t_rx || m_rx),
		.rx_sys(addr_ph || s_rx),
		.fatal(fatal_err),
		.par_o(par_o),
		.par_oe(par_oe),
		.perr_n_o(perr_n_o),
		.perr_n_oe(perr_n_oe),
		.serr_n_oe(serr_n_oe)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_cfg_miss;
		addr_ph && phs_pkg::cmd_is_cfg(cbe_n_i) && !idsel_i && (t_st_r == T_IDLE);
	endsequence

	property p_xfer;
		tgt_xfer |-> !$past(trdy_n_o) && $past(trdy_n_oe) && !$past(irdy_n_i);
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer without both readies");
	property p_devsel;
		(tgt_hit && (t_st_r == T_IDLE)) |=> (!devsel_n_o && devsel_n_oe);
	endproperty
	a_devsel: assert property (p_devsel) else $error("claimed cycle lacks devsel");
	property p_cfg;
		s_cfg_miss |=> devsel_n_o;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config claimed without select");
	property p_lock;
		(tgt_hit && (t_st_r == T_IDLE) && locked_r && !lock_n_i) |=> trdy_n_o [*2];
	endproperty
	a_lock: assert property (p_lock) else $error("locked access not retried");
	property p_rdata;
		(!trdy_n_o && rd) |-> (ad_oe && (ad_o == tad_r));
	endproperty
	a_rdata: assert property (p_rdata) else $error("read ready without data");
	property p_req;
		(m_st_r == M_REQ) |-> !req_n ##0 frame_n_oe == 1'b0;
	endproperty
	a_req: assert property (p_req) else $error("request not on own line");
	property p_gnt;
		!frame_n_o && frame_n_oe |-> !$past(gnt_n);
	endproperty
	a_gnt: assert property (p_gnt) else $error("frame driven without grant");
	property p_inta;
		irq_pending |=> (inta_n_oe && !inta_n_o);
	endproperty
	a_inta: assert property (p_inta) else $error("interrupt not held");
	property p_stop;
		((m_st_r == M_DATA) && !stop_n_i) |=> (m_st_r == M_TURN) ##1 (m_st_r == M_IDLE);
	endproperty
	a_stop: assert property (p_stop) else $error("master ignored stop");
endmodule
`default_nettype wire

// >>> verif/phs_host_model.sv
/*
 Behavioural far side of the PCI handshake block: arbiter and a memory target
 that claims master cycles whose address has bit 31 clear.
 Assumes resolved bus wires with pull-ups on the control lines.
*/
`timescale 1ns/1ps
`default_nettype none
module phs_host_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic req_n,
	input wire logic gnt_hold,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [31:0] ad,
	input wire logic [1:0] wait_cyc,
	input wire logic do_stop,
	output logic gnt_n,
	output logic p_oe,
	output logic p_devsel,
	output logic p_trdy,
	output logic p_stop,
	output logic [31:0] got_data
);
	logic [1:0] st_r;
	logic [1:0] cnt_r;
	// Wait states come from wait_cyc, so both prompt and slow answers are exercised
	wire logic go = st_r == 2'h1 && cnt_r >= wait_cyc;
	assign p_oe = st_r != 2'h0;
	assign p_devsel = st_r != 2'h1;
	assign p_trdy = !(go && !do_stop);
	assign p_stop = !(go && do_stop);
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			gnt_n <= 1'b1;
			st_r <= 2'h0;
			cnt_r <= 2'h0;
		end else begin
			gnt_n <= req_n | gnt_hold;
			cnt_r <= (st_r == 2'h1 && cnt_r != 2'h3) ? cnt_r + 2'h1 : 2'h0;
			if (st_r == 2'h0 && !frame_n && !ad[31]) begin
				st_r <= 2'h1;
			end else if (st_r == 2'h1 && go && !irdy_n) begin
				st_r <= 2'h2;
				got_data <= ad;
			end else if (st_r == 2'h2) begin
				// Turn cycle drives the lines high before letting go
				st_r <= 2'h0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
/*
 Self-checking bench for the PCI handshake block: target writes, lock,
 parity, config select, interrupt, system error and master cycles.
 Assumes the host model as far side; the bench acts as the other bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [31:0] ad_o;
	logic [3:0] cbe_n_o;
	logic ad_oe, cbe_n_oe, par_o, par_oe, frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe;
	logic trdy_n_o, trdy_n_oe, stop_n_o, stop_n_oe, devsel_n_o, devsel_n_oe;
	logic perr_n_o, perr_n_oe, serr_n_o, serr_n_oe, inta_n_o, inta_n_oe;
	logic req_n, tgt_xfer, mst_busy, mst_done;
	phs_pkg::phs_xfer_t tgt_info;
	phs_pkg::phs_xfer_t mst_req = '0;
	phs_pkg::phs_mres_t mst_res;
	logic h_oe = 1'b0, frame = 1'b1, irdy = 1'b1, par = 1'b0, lock_n_i = 1'b1, idsel_i = 1'b0;
	logic tgt_ready = 1'b1, tgt_stop = 1'b0, irq_pending = 1'b0, fatal_err = 1'b0;
	logic mst_start = 1'b0, gnt_hold = 1'b1, do_stop = 1'b0;
	logic [31:0] h_ad = 32'h0;
	logic [31:0] tgt_rdata = 32'h0;
	logic [3:0] cbe = 4'h0;
	logic [1:0] wait_cyc = 2'h0;
	logic gnt_n, p_oe, p_devsel, p_trdy, p_stop;
	logic [31:0] got_data;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// Undriven control lines float high through the pull-ups
	wire logic [31:0] ad_i = ad_oe ? ad_o : h_ad;
	wire logic [3:0] cbe_n_i = cbe_n_oe ? cbe_n_o : cbe;
	wire logic par_i = par_oe ? par_o : par;
	wire logic frame_n_i = frame_n_oe ? frame_n_o : (h_oe ? frame : 1'b1);
	wire logic irdy_n_i = irdy_n_oe ? irdy_n_o : (h_oe ? irdy : 1'b1);
	wire logic trdy_n_i = trdy_n_oe ? trdy_n_o : (p_oe ? p_trdy : 1'b1);
	wire logic stop_n_i = stop_n_oe ? stop_n_o : (p_oe ? p_stop : 1'b1);
	wire logic devsel_n_i = devsel_n_oe ? devsel_n_o : (p_oe ? p_devsel : 1'b1);

	always #25 ref_clk = ~ref_clk;

	phs_pci_handshake phs_pci_handshake_i (
		.ref_clk, .rst_b, .ad_i, .ad_o, .ad_oe, .cbe_n_i, .cbe_n_o, .cbe_n_oe,
		.par_i, .par_o, .par_oe, .frame_n_i, .frame_n_o, .frame_n_oe,
		.irdy_n_i, .irdy_n_o, .irdy_n_oe, .trdy_n_i, .trdy_n_o, .trdy_n_oe,
		.stop_n_i, .stop_n_o, .stop_n_oe, .devsel_n_i, .devsel_n_o, .devsel_n_oe,
		.lock_n_i, .idsel_i, .perr_n_o, .perr_n_oe, .serr_n_o, .serr_n_oe,
		.inta_n_o, .inta_n_oe, .req_n, .gnt_n, .tgt_rdata, .tgt_ready, .tgt_stop,
		.tgt_xfer, .tgt_info, .irq_pending, .fatal_err, .mst_start, .mst_req,
		.mst_busy, .mst_done, .mst_res
	);

	phs_host_model phs_host_model_i (
		.ref_clk, .rst_b, .req_n, .gnt_hold, .frame_n(frame_n_i), .irdy_n(irdy_n_i),
		.ad(ad_i), .wait_cyc, .do_stop, .gnt_n, .p_oe, .p_devsel, .p_trdy, .p_stop,
		.got_data
	);

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Single data phase as the other master, read or write; data is the inverted address
	task automatic tgt_cyc(input logic [31:0] a, input logic [3:0] c, input logic bad,
			input logic [1:0] lk, input logic [1:0] ex);
		logic dv;
		logic ty;
		logic rd;
		logic sp;
		logic se;
		dv = 1'b0;
		ty = 1'b0;
		rd = 1'b0;
		sp = 1'b0;
		se = 1'b0;
		@(negedge ref_clk);
		h_oe = 1'b1;
		frame = 1'b0;
		h_ad = a;
		cbe = c;
		lock_n_i = lk[1];
		tgt_rdata = ~a;
		@(negedge ref_clk);
		frame = 1'b1;
		irdy = 1'b0;
		h_ad = ~a;
		cbe = 4'h0;
		par = ^{a, c};
		lock_n_i = lk[0];
		for (int n = 0; n < 8 && !rd; n++) begin
			@(negedge ref_clk);
			par = (^{~a, 4'h0}) ^ bad;
			dv = dv | (devsel_n_i === 1'b0);
			ty = ty | (trdy_n_i === 1'b0);
			sp = sp | (stop_n_i === 1'b0);
			se = se | (serr_n_oe === 1'b1);
			// Stop ends our cycle just as target ready does
			rd = (trdy_n_i === 1'b0) || (stop_n_i === 1'b0);
			if (!c[0] && trdy_n_i === 1'b0) chk(ad_i, ~a);
		end
		@(negedge ref_clk);
		irdy = 1'b1;
		chk({dv, ty, tgt_xfer, sp}, {ex, ex[0], tgt_stop || (ex == 2'b10)});
		chk(se, bad && (c == phs_pkg::CMD_SPECIAL));
		if (ex[0]) chk(tgt_info.data, ~a);
		if (ex[0]) chk(tgt_info.addr, a);
		if (ex[0]) chk({tgt_info.cmd, tgt_info.be}, {c, 4'hf});
		@(negedge ref_clk);
		h_oe = 1'b0;
		h_ad = a;
		par = ~par;
		chk(perr_n_oe & ~perr_n_o, bad && (c != phs_pkg::CMD_SPECIAL));
		@(negedge ref_clk);
		chk(perr_n_oe & perr_n_o, bad && (c != phs_pkg::CMD_SPECIAL));
	endtask

	task automatic irq_chk;
		@(negedge ref_clk);
		irq_pending = 1'b1;
		@(negedge ref_clk);
		chk(inta_n_oe, 1'b1);
		repeat (4) @(negedge ref_clk);
		chk({inta_n_oe, inta_n_o}, 2'b10);
		irq_pending = 1'b0;
		@(negedge ref_clk);
		chk(inta_n_oe, 1'b0);
	endtask

	task automatic serr_chk;
		logic [1:0] s;
		@(negedge ref_clk);
		fatal_err = 1'b1;
		@(negedge ref_clk);
		fatal_err = 1'b0;
		s = {1'b0, serr_n_oe};
		@(negedge ref_clk);
		s = s + {1'b0, serr_n_oe};
		chk({s, serr_n_o}, 3'h2);
	endtask

	// Grant is withheld three cycles; the block must keep asking and not start
	task automatic mst(input logic [31:0] a, input logic st, input logic [1:0] ex);
		@(negedge ref_clk);
		mst_req = '{a, phs_pkg::CMD_MEM_WR, 4'hf, ~a};
		mst_start = 1'b1;
		gnt_hold = 1'b1;
		do_stop = st;
		@(negedge ref_clk);
		mst_start = 1'b0;
		repeat (3) begin
			@(negedge ref_clk);
			chk({req_n, frame_n_oe, mst_busy}, 3'b001);
		end
		gnt_hold = 1'b0;
		for (int n = 0; n < 20 && mst_done !== 1'b1; n++) @(negedge ref_clk);
		chk({mst_done, mst_res.retry, mst_res.abort}, {1'b1, ex});
		if (ex == 2'b00) chk(got_data, ~a);
		do_stop = 1'b0;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			close_out;
		end
	end

	initial begin
		repeat (3) @(negedge ref_clk);
		chk({ad_oe, trdy_n_oe, devsel_n_oe, req_n}, 4'h1);
		repeat (3) @(negedge ref_clk);
		rst_b = 1'b1;
		tgt_cyc(32'h8000_0010, phs_pkg::CMD_MEM_WR, 1'b0, 2'b10, 2'b11);
		tgt_cyc(32'h8000_0020, phs_pkg::CMD_MEM_WR, 1'b0, 2'b00, 2'b10);
		lock_n_i = 1'b1;
		tgt_cyc(32'h8000_0030, phs_pkg::CMD_MEM_WR, 1'b1, 2'b11, 2'b11);
		tgt_cyc(32'h8000_0040, phs_pkg::CMD_MEM_RD, 1'b0, 2'b11, 2'b11);
		tgt_stop = 1'b1;
		tgt_cyc(32'h8000_0050, phs_pkg::CMD_MEM_WR, 1'b0, 2'b11, 2'b11);
		tgt_stop = 1'b0;
		tgt_cyc(32'h8000_0060, phs_pkg::CMD_SPECIAL, 1'b1, 2'b11, 2'b00);
		for (int i = 0; i < 2; i++) begin
			idsel_i = i[0];
			tgt_cyc(32'h8000_0100, 4'hb, 1'b0, 2'b11, {2{i[0]}});
		end
		irq_chk;
		serr_chk;
		wait_cyc = 2'h2;
		mst(32'h0000_1000, 1'b0, 2'b00);
		wait_cyc = 2'h0;
		mst(32'h0000_2000, 1'b1, 2'b10);
		mst(32'h9000_0000, 1'b0, 2'b01);
		close_out;
	end
endmodule
`default_nettype wire
